/* tb/an_autoneg_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "an_map.svh"

// ==========
// Self-checking bench for negotiation
module an_autoneg_test;
  localparam int GAP = 20;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [4:0] reg_no = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic rvalid;
  logic flp_send;
  logic [15:0] flp_word;
  logic rx_valid;
  logic [15:0] rx_word;
  logic nlp;
  logic idle100;
  logic [4:0] dp_en;
  logic [1:0] mode = 2'h3;
  logic slow = 1'b0;
  logic link_fail = 1'b0;
  logic [15:0] abl = 16'h0001;
  logic [15:0] heard;
  logic [15:0] cadv [5] = '{16'h01e1, 16'h03e1, 16'h0061, 16'h0021, 16'h01e1};
  logic [15:0] clp [5] = '{16'h0201, 16'h0281, 16'h01e1, 16'h0021, 16'h01e1};
  int fails = 0;
  int checked = 0;

  // Device and partner
  an_autoneg #(.BURST_GAP(GAP)) DUT (
    .CLOCK(clock), .RESET(reset), .CE(1'b1), .MGMT_REG(reg_no),
    .MGMT_WR(wr), .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata),
    .MGMT_RVALID(rvalid), .FLP_SEND(flp_send), .FLP_WORD(flp_word),
    .FLP_RX_VALID(rx_valid), .FLP_RX_WORD(rx_word), .NLP_SEEN(nlp),
    .IDLE100_SEEN(idle100), .LINK_FAIL(link_fail), .DP_EN(dp_en)
  );
  an_partner partner (
    .clock(clock), .mode(mode), .slow(slow), .abl(abl),
    .flp_send(flp_send), .flp_word(flp_word), .rx_valid(rx_valid),
    .rx_word(rx_word), .nlp(nlp), .idle100(idle100), .heard(heard)
  );

  // Clock
  initial begin
    forever #50 clock = ~clock;
  end

  // ==========
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic write_reg(input logic [4:0] r, input logic [15:0] d);
    @(posedge clock);
    reg_no <= r;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] r, output logic [15:0] d);
    @(posedge clock);
    reg_no <= r;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk({15'h0000, rvalid}, 16'h0001, "read valid");
    d = rdata;
  endtask : read_reg

  // Enables of the best common technology, four-pair skipped
  function automatic logic [4:0] expect_en(input logic [15:0] both);
    if (both[8]) return 5'h19;
    if (both[7]) return 5'h18;
    if (both[6]) return 5'h07;
    if (both[5]) return 5'h06;
    return 5'h00;
  endfunction : expect_en

  task automatic negotiate(input logic [15:0] adv, input logic [15:0] lp);
    logic [15:0] v;
    logic [4:0] e;
    e = expect_en(adv & lp);
    mode <= 2'h0;
    abl <= lp;
    write_reg(`AN_REG_ADV, adv);
    write_reg(`AN_REG_CTRL, 16'h1200);
    read_reg(`AN_REG_CTRL, v);
    chk({14'h0000, v[12], v[9]}, 16'h0002, "restart");
    read_reg(`AN_REG_ADV, v);
    chk(v, adv & 16'hfdff, "advert");
    for (int i = 0; i < 40; i++) begin
      read_reg(`AN_REG_STAT, v);
      if (v[5] === 1'b1) break;
    end
    chk({15'h0000, v[5]}, {15'h0000, |e}, "done");
    repeat (3) @(posedge clock);
    #1;
    chk({11'h000, dp_en}, {11'h000, e}, "path");
    read_reg(`AN_REG_LPA, v);
    chk(v, lp | 16'h4000, "partner");
    read_reg(`AN_REG_DSTAT, v);
    chk({13'h0, v[15:14], v[4]}, {13'h0, e[4], e[0], |e}, "mirror");
    chk(heard & 16'h3dff, adv & 16'h3dff, "burst");
    $display("test negotiate %h %h done", adv, lp);
  endtask : negotiate

  task automatic detect(input logic [1:0] m, input logic [15:0] lbit,
                        input logic [4:0] e, input logic fault);
    logic [15:0] v;
    mode <= m;
    write_reg(`AN_REG_CTRL, 16'h1200);
    read_reg(`AN_REG_EXP, v);
    repeat (4 * GAP) @(posedge clock);
    read_reg(`AN_REG_EXP, v);
    chk({14'h0, v[4], v[0]}, {14'h0, fault, 1'b0}, "expansion");
    read_reg(`AN_REG_STAT, v);
    chk({15'h0000, v[5]}, {15'h0000, ~fault}, "legacy done");
    read_reg(`AN_REG_LPA, v);
    chk(v & 16'h00a0, lbit, "sensed");
    chk({11'h000, dp_en}, {11'h000, e}, "legacy path");
    $display("test detect %h done", m);
  endtask : detect

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // ==========
  // Watchdog
  initial begin
    repeat (6000) @(posedge clock);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end

  // Test sequence
  initial begin
    logic [15:0] v;
    logic [31:0] r;
    int n;
    void'($urandom(97));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    read_reg(`AN_REG_CTRL, v);
    chk({15'h0000, v[12]}, 16'h0001, "enable");
    read_reg(`AN_REG_ADV, v);
    chk(v, 16'h01e1, "advert reset");
    write_reg(5'h03, 16'hffff);
    read_reg(5'h03, v);
    chk(v, 16'h0000, "unmapped");
    write_reg(`AN_REG_STAT, 16'hffff);
    read_reg(`AN_REG_STAT, v);
    chk({14'h0000, v[5], v[3]}, 16'h0001, "status");
    $display("test reset done");
    // Disabled negotiation sends nothing
    write_reg(`AN_REG_CTRL, 16'h0000);
    n = 0;
    repeat (3 * GAP) begin
      @(posedge clock);
      #1;
      n += int'(flp_send === 1'b1);
    end
    chk(n[15:0], 16'h0000, "bursts off");
    $display("test disable done");
    detect(2'h3, 16'h0000, 5'h00, 1'b1);
    detect(2'h1, 16'h0020, 5'h06, 1'b0);
    detect(2'h2, 16'h0080, 5'h18, 1'b0);
    for (int i = 0; i < 5; i++) negotiate(cadv[i], clp[i]);
    // Link loss after completion drops done and the datapath
    @(posedge clock);
    link_fail <= 1'b1;
    @(posedge clock);
    link_fail <= 1'b0;
    read_reg(`AN_REG_STAT, v);
    chk({15'h0000, v[5]}, 16'h0000, "link lost");
    chk({11'h000, dp_en}, 16'h0000, "link lost path");
    $display("test link loss done");
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      slow <= r[16];
      negotiate((r[15:0] & 16'h03e0) | 16'h0001,
                (r[31:16] & 16'h03e0) | 16'h0001);
    end
    conclude();
  end
endmodule : an_autoneg_test

`default_nettype wire

/* tb/an_partner.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========
// Remote link partner on the cable
module an_partner (
  input wire logic clock,           // Shared clock
  input wire logic [1:0] mode,      // 0 bursts, 1 pulses, 2 idles, 3 both
  input wire logic slow,            // Answer late
  input wire logic [15:0] abl,      // Own ability word
  input wire logic flp_send,        // Burst from device
  input wire logic [15:0] flp_word, // Word of that burst
  output logic rx_valid,            // Decoded reply
  output logic [15:0] rx_word,      // Reply word
  output logic nlp,                 // Normal link pulses
  output logic idle100,             // Scrambled idles
  output logic [15:0] heard         // Last word received
);
  logic valid_q = 1'b0;
  logic ack = 1'b0;
  logic [15:0] word_q = 16'h0000;
  logic [15:0] heard_q = 16'h0000;
  int wait_n = 0;

  // Legacy signalling stands in for bursts
  assign nlp = mode[0];
  assign idle100 = mode[1];
  assign rx_valid = valid_q;
  assign rx_word = word_q;
  assign heard = heard_q;

  // Answer each burst later in mode 0, acknowledging once heard
  always @(posedge clock) begin
    valid_q <= 1'b0;
    word_q <= ~word_q; // Undriven word keeps changing
    if (flp_send) begin
      heard_q <= flp_word;
      ack <= 1'b1;
      wait_n <= slow ? 9 : 2;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end
    if (wait_n == 1 && mode == 2'h0) begin
      valid_q <= 1'b1;
      word_q <= abl | {1'b0, ack, 14'h0000};
    end
  end
endmodule : an_partner

`default_nettype wire

/* verilog/an_autoneg.sv */
`timescale 1ns/10ps
`default_nettype none
`include "an_map.svh"

// ==========================================================================
// Summary of operation
// - Negotiation runs only when locally enabled, whether or not the partner sends bursts.
// - Outgoing burst words are taken from the advertisement register.
// - While negotiating, bursts carrying the link control word are sent.
// - Partner words received in bursts are written to the partner register.
// - After exchange, the two registers are compared for a common technology.
// - Priority runs 100 full, 100 half, 10 full, 10 half.
// - The four-pair technology is never chosen or advertised.
// - Completion sets the status done bit and its detailed status mirror.
// - After completion the chosen technology's transmit and receive are on.
// - After completion every technology not chosen is switched off.
// - A legacy 10 Mb/s partner is detected and selected without management.
// - Parallel detection sets partner bit 5 or 7 for the sensed technology.
// - Several technologies sensed at once set the parallel fault flag.
// - Writing the restart bit restarts negotiation and the bit self-clears.
module an_autoneg
  import an_pkg::*;
#(
  parameter int BURST_GAP = `AN_BURST_GAP_US * `AN_CLK_MHZ // Burst spacing
) (
  input wire logic CLOCK,              // 10 MHz clock
  input wire logic RESET,              // Synchronous reset, high
  input wire logic CE,                 // Clock enable
  input wire logic [4:0] MGMT_REG,     // Register number
  input wire logic MGMT_WR,            // Write strobe
  input wire logic MGMT_RD,            // Read strobe
  input wire logic [15:0] MGMT_WDATA,  // Write data
  output logic [15:0] MGMT_RDATA,      // Read data
  output logic MGMT_RVALID,            // Read data valid
  output logic FLP_SEND,               // Send one burst
  output logic [15:0] FLP_WORD,        // Word for that burst
  input wire logic FLP_RX_VALID,       // Partner word received
  input wire logic [15:0] FLP_RX_WORD, // Partner word
  input wire logic NLP_SEEN,           // Normal link pulses sensed
  input wire logic IDLE100_SEEN,       // 100M idles sensed
  input wire logic LINK_FAIL,          // Link lost
  output var an_dp_en_s DP_EN          // Datapath enables
);

  an_state_e state;
  an_tech_e res_tech;
  an_tech_e tech_sel;
  logic an_enable;
  logic [15:0] adv;
  logic [15:0] lpa;
  logic lp_able;
  logic pd_fault;
  logic an_done;
  logic ack_want;
  logic ack_sent;
  logic [`AN_GAP_W-1:0] gap_cnt;
  logic [`AN_MISS_W-1:0] miss_cnt;
  logic restart_req;
  logic exch_done;
  logic pd_try;
  logic pd_hit;
  logic pd_fault_set;
  logic exp_read;

  // ========================================================================
  // Request decode
  assign restart_req = MGMT_WR && MGMT_REG == `AN_REG_CTRL &&
                       MGMT_WDATA[`AN_CTRL_RESTART];
  assign exp_read = MGMT_RD && MGMT_REG == `AN_REG_EXP;
  assign exch_done = state == ST_SEND && FLP_RX_VALID &&
                     FLP_RX_WORD[`AN_ABL_ACK] && ack_sent;
  assign pd_try = state == ST_SEND && !lp_able &&
                  miss_cnt >= `AN_PD_BURSTS;
  assign pd_hit = pd_try && (NLP_SEEN ^ IDLE100_SEEN);
  assign pd_fault_set = pd_try && NLP_SEEN && IDLE100_SEEN;

  // ========================================================================
  // Resolver on the two ability words
  an_resolve u_resolve (
    .local_abl(adv),
    .partner_abl(lpa),
    .tech(res_tech)
  );

  // Control register: enable bit
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      an_enable <= `AN_CTRL_RESET;
    end else if (CE && MGMT_WR && MGMT_REG == `AN_REG_CTRL) begin
      an_enable <= MGMT_WDATA[`AN_CTRL_AN_EN];
    end
  end

  // Advertisement register, four-pair bit held low
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      adv <= `AN_ADV_RESET;
    end else if (CE && MGMT_WR && MGMT_REG == `AN_REG_ADV) begin
      adv <= MGMT_WDATA & `AN_ADV_WMASK;
    end
  end

  // ========================================================================
  // Arbitration state machine
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= ST_IDLE;
    end else if (CE) begin
      if (!an_enable || restart_req ||
          (state == ST_DONE && LINK_FAIL)) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: state <= ST_SEND;
          ST_SEND: begin
            if (exch_done || pd_hit) begin
              state <= ST_RESOLVE;
            end
          end
          ST_RESOLVE: state <= (res_tech == TECH_NONE) ? ST_NOMATCH :
                                ST_DONE;
          ST_DONE, ST_NOMATCH: state <= state; // Held until restart or disable; done also leaves on link loss
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ========================================================================
  // Burst timer and missed-burst count
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gap_cnt <= '0;
      miss_cnt <= '0;
    end else if (CE) begin
      if (state != ST_SEND) begin
        gap_cnt <= '0;
        miss_cnt <= '0;
      end else begin
        gap_cnt <= (gap_cnt == `AN_GAP_W'(BURST_GAP - 1)) ? '0 :
                   gap_cnt + 1'b1;
        if (gap_cnt == '0 && miss_cnt != '1) begin
          miss_cnt <= miss_cnt + 1'b1;
        end
      end
    end
  end

  // Outgoing burst strobe and link control word
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      FLP_SEND <= 1'b0;
      FLP_WORD <= `AN_WORD_ZERO;
    end else if (CE) begin
      FLP_SEND <= state == ST_SEND && gap_cnt == '0;
      FLP_WORD <= adv & `AN_ADV_WMASK;
      FLP_WORD[`AN_ABL_ACK] <= ack_want;
    end
  end

  // Acknowledge tracking
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ack_want <= 1'b0;
      ack_sent <= 1'b0;
    end else if (CE) begin
      if (state == ST_IDLE) begin
        ack_want <= 1'b0;
        ack_sent <= 1'b0;
      end else begin
        if (state == ST_SEND && FLP_RX_VALID) begin
          ack_want <= 1'b1;
        end
        if (FLP_SEND && FLP_WORD[`AN_ABL_ACK]) begin
          ack_sent <= 1'b1;
        end
      end
    end
  end

  // ========================================================================
  // Partner ability register and partner-able flag
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      lpa <= `AN_WORD_ZERO;
      lp_able <= 1'b0;
    end else if (CE) begin
      if (state == ST_IDLE) begin
        lpa <= `AN_WORD_ZERO;
        lp_able <= 1'b0;
      end else if (state == ST_SEND && FLP_RX_VALID) begin
        lpa <= FLP_RX_WORD;
        lp_able <= 1'b1;
      end else if (pd_hit) begin
        lpa[NLP_SEEN ? `AN_ABL_10HD : `AN_ABL_100HD] <= 1'b1;
      end
    end
  end

  // Parallel fault flag, cleared by reading, set wins
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pd_fault <= 1'b0;
    end else if (CE) begin
      if (pd_fault_set) begin
        pd_fault <= 1'b1;
      end else if (exp_read) begin
        pd_fault <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Result, completion flag and datapath enables
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      tech_sel <= TECH_NONE;
      an_done <= 1'b0;
    end else if (CE) begin
      tech_sel <= (state == ST_RESOLVE) ? res_tech : tech_sel;
      an_done <= an_enable && !restart_req &&
                 ((state == ST_RESOLVE && res_tech != TECH_NONE) ||
                  (state == ST_DONE && !LINK_FAIL));
    end
  end

  // Only the chosen technology is powered
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      DP_EN <= '0;
    end else if (CE) begin
      DP_EN <= (state == ST_DONE) ? an_tech_en(tech_sel) :
               '0;
    end
  end

  // ========================================================================
  // Register read
  function automatic logic [15:0] reg_read(input logic [4:0] num);
    logic [15:0] d;
    d = `AN_WORD_ZERO;
    case (num)
      `AN_REG_CTRL: d[`AN_CTRL_AN_EN] = an_enable;
      `AN_REG_STAT: begin
        d[`AN_STAT_AN_ABLE] = 1'b1;
        d[`AN_STAT_AN_DONE] = an_done;
      end
      `AN_REG_ADV: d = adv;
      `AN_REG_LPA: d = lpa;
      `AN_REG_EXP: begin
        d[`AN_EXP_LP_ABLE] = lp_able;
        d[`AN_EXP_PD_FAULT] = pd_fault;
      end
      `AN_REG_DSTAT: begin
        d[`AN_DST_DONE] = an_done;
        d[`AN_DST_RATE] = an_done &&
                          (tech_sel == TECH_100FD || tech_sel == TECH_100HD);
        d[`AN_DST_DUPLEX] = an_done &&
                            (tech_sel == TECH_100FD || tech_sel == TECH_10FD);
      end
      default: d = `AN_WORD_ZERO;
    endcase
    return d;
  endfunction : reg_read

  // Read data one cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      MGMT_RDATA <= `AN_WORD_ZERO;
      MGMT_RVALID <= 1'b0;
    end else if (CE) begin
      MGMT_RVALID <= MGMT_RD;
      if (MGMT_RD) begin
        MGMT_RDATA <= reg_read(MGMT_REG);
      end
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence s_live;
    CE && an_enable && !restart_req;
  endsequence

  sequence s_resolved;
    s_live ##0 state == ST_RESOLVE && res_tech != TECH_NONE;
  endsequence

  chk_disabled_idle: assert property (
    CE && !an_enable |=> state == ST_IDLE)
    else $error("negotiation ran while disabled");
  chk_burst_word: assert property (
    FLP_SEND |-> FLP_WORD[13:0] == $past(adv[13:0]) &&
    !FLP_WORD[`AN_ABL_T4])
    else $error("burst word differs from advertisement");
  chk_lpa_store: assert property (
    CE && state == ST_SEND && FLP_RX_VALID |=> lpa == $past(FLP_RX_WORD))
    else $error("partner word not stored");
  chk_top_priority: assert property (
    s_live ##0 state == ST_RESOLVE && adv[`AN_ABL_100FD] &&
    lpa[`AN_ABL_100FD] |=> tech_sel == TECH_100FD && state == ST_DONE)
    else $error("100 full duplex not chosen");
  chk_t4_excluded: assert property (
    s_live ##0 state == ST_RESOLVE && lpa[`AN_ABL_T4] &&
    (adv & lpa & 16'h01e0) == `AN_WORD_ZERO |=> state == ST_NOMATCH)
    else $error("four-pair alone did not give no match");
  chk_done_mirror: assert property (
    s_resolved |=> an_done ##0 state == ST_DONE)
    else $error("done flag not set on completion");
  chk_enable_dp: assert property (
    s_resolved ##1 (CE && state == ST_DONE)
    |=> DP_EN == an_tech_en(tech_sel) && DP_EN != '0)
    else $error("datapath enables wrong after completion");
  chk_unused_off: assert property (
    CE && state != ST_DONE &&
    !(state == ST_RESOLVE && res_tech != TECH_NONE)
    |=> DP_EN == '0 && !an_done)
    else $error("datapath on without completion");
  chk_legacy_pd: assert property (
    s_live ##0 pd_hit && NLP_SEEN
    |=> lpa[`AN_ABL_10HD] && state == ST_RESOLVE)
    else $error("legacy partner not detected");
  chk_pd_fault: assert property (
    CE && pd_fault_set |=> pd_fault)
    else $error("parallel fault flag not set");
  chk_restart_bit: assert property (
    CE && restart_req ##[1:2] CE && MGMT_RD && MGMT_REG == `AN_REG_CTRL
    |=> state != ST_DONE && !MGMT_RDATA[`AN_CTRL_RESTART])
    else $error("restart did not act or did not self-clear");

endmodule : an_autoneg

`default_nettype wire

/* verilog/an_map.svh */
`ifndef AN_MAP_SVH
`define AN_MAP_SVH

// ==========================================================================
// Register numbers on the management port
`define AN_REG_CTRL 5'h00
`define AN_REG_STAT 5'h01
`define AN_REG_ADV 5'h04
`define AN_REG_LPA 5'h05
`define AN_REG_EXP 5'h06
`define AN_REG_DSTAT 5'h11

// ==========================================================================
// Field positions
`define AN_CTRL_RESTART 9
`define AN_CTRL_AN_EN 12
`define AN_STAT_AN_ABLE 3
`define AN_STAT_AN_DONE 5
`define AN_ABL_10HD 5
`define AN_ABL_10FD 6
`define AN_ABL_100HD 7
`define AN_ABL_100FD 8
`define AN_ABL_T4 9
`define AN_ABL_ACK 14
`define AN_EXP_LP_ABLE 0
`define AN_EXP_PD_FAULT 4
`define AN_DST_DONE 4
`define AN_DST_DUPLEX 14
`define AN_DST_RATE 15

// ==========================================================================
// Reset values and masks
`define AN_CTRL_RESET 1'h1
`define AN_ADV_RESET 16'h01e1
`define AN_ADV_WMASK 16'hfdff
`define AN_WORD_ZERO 16'h0000

// ==========================================================================
// Timing
`define AN_CLK_MHZ 10
`define AN_BURST_GAP_US 16000
`define AN_GAP_W 24
`define AN_PD_BURSTS 3'h3
`define AN_MISS_W 3

`endif

/* verilog/an_pkg.sv */
// ==========================================================================
// Shared types
package an_pkg;

  // Technology chosen by resolution
  typedef enum logic [2:0] {
    TECH_NONE,
    TECH_100FD,
    TECH_100HD,
    TECH_10FD,
    TECH_10HD
  } an_tech_e;

  // Arbitration states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEND,
    ST_RESOLVE,
    ST_DONE,
    ST_NOMATCH
  } an_state_e;

  // Datapath enables toward the transceivers
  typedef struct packed {
    logic tx100;
    logic rx100;
    logic tx10;
    logic rx10;
    logic full_duplex;
  } an_dp_en_s;

  // Enables for one technology, all others off
  function automatic an_dp_en_s an_tech_en(input an_tech_e tech);
    an_dp_en_s en;
    en = '0;
    case (tech)
      TECH_100FD: en = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      TECH_100HD: en = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      TECH_10FD: en = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      TECH_10HD: en = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      default: en = '0;
    endcase
    return en;
  endfunction : an_tech_en

endpackage : an_pkg

/* verilog/an_resolve.sv */
`timescale 1ns/10ps
`default_nettype none
`include "an_map.svh"

// ==========================================================================
// Highest-priority common technology
module an_resolve
  import an_pkg::*;
(
  input wire logic [15:0] local_abl,   // Own advertisement
  input wire logic [15:0] partner_abl, // Partner abilities
  output var an_tech_e tech            // Chosen technology
);

  logic [15:0] common;

  // Shared abilities
  assign common = local_abl & partner_abl;

  // Fixed priority walk, four-pair never chosen
  always_comb begin
    if (common[`AN_ABL_100FD]) begin
      tech = TECH_100FD;
    end else if (common[`AN_ABL_100HD]) begin
      tech = TECH_100HD;
    end else if (common[`AN_ABL_10FD]) begin
      tech = TECH_10FD;
    end else if (common[`AN_ABL_10HD]) begin
      tech = TECH_10HD;
    end else begin
      tech = TECH_NONE;
    end
  end

endmodule : an_resolve

`default_nettype wire
